// ==== osc_cfg_pkg.sv ====
// Operation
// - boost bit selects stronger crystal kick-start
// - two-bit gain field selects crystal drive strength
// - lock gating disables pll output on lost lock
// - switch mode decodes switching and monitor enables
// - outside crystal modes pin is clock or gpio
// - mode field selects off, hs, xt or ec
// - configuration word is program-once, writes ignored
// - pll request while pll stopped waits time-out
package osc_cfg_pkg;
   localparam int CFG_W = 24;
   localparam int ADDR_W = 12;
   localparam logic [CFG_W-1:0] CFG_RESET = 24'hffffff;
   localparam logic [CFG_W-1:0] CFG_UNIMPL = 24'hffe238;
   localparam int BOOST_BIT = 12;
   localparam int GAIN_LSB = 10;
   localparam int LOCKGATE_BIT = 8;
   localparam int SWMODE_LSB = 6;
   localparam int PINFN_BIT = 2;
   localparam int MODE_LSB = 0;
   localparam logic [1:0] MODE_OFF = 2'h3;
   localparam logic [1:0] MODE_HS = 2'h2;
   localparam logic [1:0] MODE_XT = 2'h1;
   localparam logic [1:0] MODE_EC = 2'h0;
   localparam logic [1:0] SWMODE_BOTH = 2'h0;
   localparam logic [1:0] SWMODE_SWITCH_ONLY = 2'h1;
   localparam logic [ADDR_W-1:0] OFF_CFG = 12'h000;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h004;
   localparam logic [ADDR_W-1:0] OFF_CLEAR = 12'h008;
   localparam logic [ADDR_W-1:0] OFF_ENABLE = 12'h00c;
   localparam logic [ADDR_W-1:0] OFF_SWSTATE = 12'h010;
   localparam int EVT_W = 4;
   localparam int EVT_DONE = 0;
   localparam int EVT_REFUSED = 1;
   localparam int EVT_LOCKLOST = 2;
   localparam int EVT_WRITE = 3;
   localparam logic [EVT_W-1:0] ENABLE_RESET = 4'h0;
   localparam int CLK_PERIOD_NS = 25;
   localparam int PLL_WAIT_NS = 10000;
   localparam int PLL_WAIT_CYCLES = (PLL_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOAD_CYCLES = 3;
   typedef struct packed {
      logic osc_off;
      logic high_speed_crystal_mode;
      logic standard_crystal_mode;
      logic external_clock_input_mode;
      logic [1:0] crystal_drive_gain;
      logic kick_start_boost;
      logic pll_lock_gate_enable;
      logic switch_enable;
      logic monitor_enable;
      logic pin_clock_out;
      logic pin_gpio;
   } osc_settings_t;
   localparam osc_settings_t SETTINGS_RESET = '0;
   typedef enum logic [1:0] {
      CS_RESET = 2'b01,
      CS_LOADED = 2'b10
   } cfg_state_t;
   typedef enum logic [2:0] {
      SW_IDLE = 3'b001,
      SW_WAIT = 3'b010,
      SW_DONE = 3'b100
   } sw_state_t;
endpackage

// ==== sync2.sv ====
`timescale 1ns/100ps
module sync2 #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   // meta is read by q only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// ==== event_flags.sv ====
`timescale 1ns/100ps
module event_flags #(
   parameter int N = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [N-1:0] set,
   input wire logic [N-1:0] clr,
   input wire logic [N-1:0] en,
   output logic [N-1:0] status,
   output logic irq
);
   logic [N-1:0] next_status;
   // set wins over a clear in the same cycle
   always_comb begin
      next_status = (status & ~clr) | set;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= '0;
         irq <= 1'b0;
      end else begin
         status <= next_status;
         irq <= |(next_status & en);
      end
   end
endmodule

// ==== osc_cfg_top.sv ====
`timescale 1ns/100ps
module osc_cfg_top
   import osc_cfg_pkg::*;
#(
   parameter int PLL_WAIT = PLL_WAIT_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [CFG_W-1:0] nvm_word,
   input wire logic pll_request,
   input wire logic pll_running,
   input wire logic pll_lock,
   output osc_settings_t settings,
   output logic cfg_valid,
   output logic pll_clock_enable,
   output logic pll_selected,
   output logic switch_busy,
   output logic irq
);
   localparam int WAIT_W = $clog2(PLL_WAIT + 1);
   localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(PLL_WAIT - 1);
   localparam logic [1:0] LOAD_LAST = 2'(LOAD_CYCLES - 1);

   logic [CFG_W-1:0] nvm_sync;
   logic [2:0] pins_sync;
   logic req_s;
   logic running_s;
   logic lock_s;
   logic lock_d;
   logic req_d;
   cfg_state_t cs;
   logic [1:0] load_count;
   logic [CFG_W-1:0] cfg_word;
   sw_state_t sw_state;
   logic [WAIT_W-1:0] wait_count;
   logic [EVT_W-1:0] enable;
   logic [EVT_W-1:0] status;
   logic [EVT_W-1:0] evt_set;
   logic [EVT_W-1:0] evt_clr;
   logic wr_access;
   logic rd_setup;
   logic mapped;
   logic cfg_write;
   logic go;
   logic [1:0] mode_f;
   logic [1:0] swmode_f;
   logic crystal;

   sync2 #(.W(CFG_W)) u_nvm_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(nvm_word),
      .q(nvm_sync)
   );

   sync2 #(.W(3)) u_pin_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({pll_request, pll_running, pll_lock}),
      .q(pins_sync)
   );

   assign req_s = pins_sync[2];
   assign running_s = pins_sync[1];
   assign lock_s = pins_sync[0];

   // word captured once the synchroniser has settled after reset release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cs <= CS_RESET;
         load_count <= 2'h0;
         cfg_word <= CFG_RESET;
         cfg_valid <= 1'b0;
      end else begin
         case (cs)
            CS_RESET: begin
               if (load_count == LOAD_LAST) begin
                  cfg_word <= nvm_sync | CFG_UNIMPL;
                  cs <= CS_LOADED;
                  cfg_valid <= 1'b1;
               end else begin
                  load_count <= load_count + 2'h1;
               end
            end
            CS_LOADED: begin
               cs <= CS_LOADED;
            end
            default: begin
               cs <= CS_RESET;
            end
         endcase
      end
   end

   assign mode_f = cfg_word[MODE_LSB +: 2];
   assign swmode_f = cfg_word[SWMODE_LSB +: 2];
   assign crystal = (mode_f == MODE_HS) || (mode_f == MODE_XT);

   // decode held at zero until the word is loaded, so clock logic sees no junk
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settings <= SETTINGS_RESET;
      end else if (cs == CS_LOADED) begin
         settings.osc_off <= (mode_f == MODE_OFF);
         settings.high_speed_crystal_mode <= (mode_f == MODE_HS);
         settings.standard_crystal_mode <= (mode_f == MODE_XT);
         settings.external_clock_input_mode <= (mode_f == MODE_EC);
         settings.crystal_drive_gain <= cfg_word[GAIN_LSB +: 2];
         settings.kick_start_boost <= cfg_word[BOOST_BIT];
         settings.pll_lock_gate_enable <= cfg_word[LOCKGATE_BIT];
         settings.switch_enable <= !swmode_f[1];
         settings.monitor_enable <= (swmode_f == SWMODE_BOTH);
         settings.pin_clock_out <= !crystal && cfg_word[PINFN_BIT];
         settings.pin_gpio <= !crystal && !cfg_word[PINFN_BIT];
      end
   end

   // pll output gated only when gating is on and lock is gone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pll_clock_enable <= 1'b0;
         lock_d <= 1'b0;
      end else begin
         pll_clock_enable <= !(settings.pll_lock_gate_enable && !lock_s);
         lock_d <= lock_s;
      end
   end

   assign go = req_s && !req_d && cfg_valid;

   // clock switch to pll; a stopped pll costs a full time-out first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_state <= SW_IDLE;
         wait_count <= '0;
         pll_selected <= 1'b0;
         switch_busy <= 1'b0;
         req_d <= 1'b0;
      end else begin
         req_d <= req_s;
         case (sw_state)
            SW_IDLE: begin
               wait_count <= '0;
               if (go && settings.switch_enable) begin
                  if (running_s) begin
                     sw_state <= SW_DONE;
                     pll_selected <= 1'b1;
                  end else begin
                     sw_state <= SW_WAIT;
                     switch_busy <= 1'b1;
                  end
               end
            end
            SW_WAIT: begin
               if (wait_count == WAIT_LAST) begin
                  sw_state <= SW_DONE;
                  pll_selected <= 1'b1;
                  switch_busy <= 1'b0;
               end else begin
                  wait_count <= wait_count + 1'b1;
               end
            end
            SW_DONE: begin
               if (!req_s) begin
                  sw_state <= SW_IDLE;
                  pll_selected <= 1'b0;
               end
            end
            default: begin
               sw_state <= SW_IDLE;
               pll_selected <= 1'b0;
               switch_busy <= 1'b0;
            end
         endcase
      end
   end

   assign wr_access = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign cfg_write = wr_access && (paddr == OFF_CFG);
   assign mapped = (paddr == OFF_CFG) || (paddr == OFF_STATUS) || (paddr == OFF_CLEAR)
      || (paddr == OFF_ENABLE) || (paddr == OFF_SWSTATE);

   always_comb begin
      evt_set = '0;
      evt_set[EVT_DONE] = (sw_state != SW_DONE) && (sw_state != SW_IDLE || go)
         && ((sw_state == SW_WAIT && wait_count == WAIT_LAST)
         || (sw_state == SW_IDLE && settings.switch_enable && running_s));
      evt_set[EVT_REFUSED] = go && (sw_state == SW_IDLE) && !settings.switch_enable;
      evt_set[EVT_LOCKLOST] = lock_d && !lock_s && settings.pll_lock_gate_enable;
      evt_set[EVT_WRITE] = cfg_write;
      evt_clr = '0;
      if (wr_access && paddr == OFF_CLEAR) begin
         evt_clr = pwdata[EVT_W-1:0];
      end
   end

   event_flags #(.N(EVT_W)) u_flags (
      .pclk(pclk),
      .presetn(presetn),
      .set(evt_set),
      .clr(evt_clr),
      .en(enable),
      .status(status),
      .irq(irq)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable <= ENABLE_RESET;
      end else if (wr_access && paddr == OFF_ENABLE) begin
         enable <= pwdata[EVT_W-1:0];
      end
   end

   // zero-wait slave: read data registered in setup, valid in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= 1'b1;
         if (psel && !penable) begin
            pslverr <= !mapped;
         end
         if (rd_setup) begin
            case (paddr)
               OFF_CFG: prdata <= {8'h00, cfg_word};
               OFF_STATUS: prdata <= {28'h0, status};
               OFF_ENABLE: prdata <= {28'h0, enable};
               OFF_SWSTATE: prdata <= {28'h0, switch_busy, pll_selected, sw_state[2], cfg_valid};
               default: prdata <= 32'h0;
            endcase
         end
      end
   end

   property p_boost;
      @(posedge pclk) disable iff (!presetn)
      (cs == CS_LOADED) |=> settings.kick_start_boost == $past(cfg_word[BOOST_BIT]);
   endproperty
   a_boost: assert property (p_boost) else $error("boost not decoded");

   property p_gain;
      @(posedge pclk) disable iff (!presetn)
      (cs == CS_LOADED) |=> settings.crystal_drive_gain == $past(cfg_word[GAIN_LSB +: 2]);
   endproperty
   a_gain: assert property (p_gain) else $error("gain not decoded");

   property p_lock_gate;
      @(posedge pclk) disable iff (!presetn)
      (settings.pll_lock_gate_enable && !lock_s) ##1 !lock_s[*2] |-> !pll_clock_enable;
   endproperty
   a_lock_gate: assert property (p_lock_gate) else $error("pll kept on after lost lock");

   property p_lock_ignored;
      @(posedge pclk) disable iff (!presetn)
      // gated on load so the release edge of reset cannot start an attempt
      cfg_valid && !settings.pll_lock_gate_enable ##1 !settings.pll_lock_gate_enable
         |-> pll_clock_enable;
   endproperty
   a_lock_ignored: assert property (p_lock_ignored) else $error("pll gated while off");

   property p_swmode;
      @(posedge pclk) disable iff (!presetn)
      (cs == CS_LOADED) |=> (settings.switch_enable == !$past(swmode_f[1]))
         && (settings.monitor_enable == ($past(swmode_f) == SWMODE_BOTH));
   endproperty
   a_swmode: assert property (p_swmode) else $error("switch mode decode wrong");

   property p_refused;
      @(posedge pclk) disable iff (!presetn)
      (sw_state == SW_IDLE && go && !settings.switch_enable) |=> (sw_state == SW_IDLE);
   endproperty
   a_refused: assert property (p_refused) else $error("switch taken while disabled");

   property p_pin;
      @(posedge pclk) disable iff (!presetn)
      (cs == CS_LOADED && !crystal) |=> settings.pin_clock_out == $past(cfg_word[PINFN_BIT])
         && settings.pin_gpio == !$past(cfg_word[PINFN_BIT]);
   endproperty
   a_pin: assert property (p_pin) else $error("pin function wrong");

   property p_mode;
      @(posedge pclk) disable iff (!presetn)
      cfg_valid ##1 1'b1 |-> $onehot({settings.osc_off, settings.high_speed_crystal_mode,
         settings.standard_crystal_mode, settings.external_clock_input_mode});
   endproperty
   a_mode: assert property (p_mode) else $error("mode flags not one-hot");

   property p_ro;
      @(posedge pclk) disable iff (!presetn)
      (cs == CS_LOADED && cfg_write) |=> $stable(cfg_word) && status[EVT_WRITE];
   endproperty
   a_ro: assert property (p_ro) else $error("config word changed by write");

   property p_timeout;
      @(posedge pclk) disable iff (!presetn)
      $rose(pll_selected) && $past(sw_state) == SW_WAIT |-> $past(wait_count) == WAIT_LAST;
   endproperty
   a_timeout: assert property (p_timeout) else $error("pll switch skipped time-out");

   property p_wait_entry;
      @(posedge pclk) disable iff (!presetn)
      (sw_state == SW_IDLE && go && settings.switch_enable && !running_s)
         |=> sw_state == SW_WAIT && switch_busy && !pll_selected;
   endproperty
   a_wait_entry: assert property (p_wait_entry) else $error("no wait on stopped pll");

   property p_load;
      @(posedge pclk) disable iff (!presetn)
      $rose(cfg_valid) |-> $past(load_count) == LOAD_LAST && cfg_word == ($past(nvm_sync) | CFG_UNIMPL);
   endproperty
   a_load: assert property (p_load) else $error("config word load wrong");

   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      cfg_valid |=> cfg_valid && $stable(cfg_word);
   endproperty
   a_hold: assert property (p_hold) else $error("config word not held");
endmodule

// ==== pll_src_model.sv ====
`timescale 1ns/100ps
module pll_src_model #(
   parameter int LOCK_DELAY = 6
) (
   input wire logic pclk,
   input wire logic power_on,
   input wire logic drop_lock,
   output logic pll_running,
   output logic pll_lock
);
   int cnt = 0;
   always @(posedge pclk) begin
      if (!power_on) begin
         cnt <= 0;
      end else if (cnt < LOCK_DELAY) begin
         cnt <= cnt + 1;
      end
   end
   assign pll_running = power_on;
   // lock only after settling; a glitch loses it at once
   assign pll_lock = power_on && cnt >= LOCK_DELAY && !drop_lock;
endmodule

// ==== tb.sv ====
`timescale 1ns/100ps
module tb;
   import osc_cfg_pkg::*;
   localparam int WAIT = 8;
   logic pclk = 0;
   logic presetn = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rd, r;
   logic pready, pslverr, err, pll_running, pll_lock;
   logic pll_request = 0;
   logic power_on = 0;
   logic drop_lock = 0;
   logic [CFG_W-1:0] nvm_word = '1;
   osc_settings_t settings;
   logic cfg_valid, pll_clock_enable, pll_selected, switch_busy, irq;
   int bad_count = 0;
   int total_checks = 0;
   int n;

   always #12.5 pclk = ~pclk;

   osc_cfg_top #(.PLL_WAIT(WAIT)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .nvm_word(nvm_word), .pll_request(pll_request),
      .pll_running(pll_running), .pll_lock(pll_lock), .settings(settings),
      .cfg_valid(cfg_valid), .pll_clock_enable(pll_clock_enable),
      .pll_selected(pll_selected), .switch_busy(switch_busy), .irq(irq));
   pll_src_model src_u (.pclk(pclk), .power_on(power_on), .drop_lock(drop_lock),
      .pll_running(pll_running), .pll_lock(pll_lock));

   task check(input logic ok, input string msg);
      total_checks++;
      if (!ok) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask

   task complete_run;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic osc_settings_t exp_set(input logic [CFG_W-1:0] w);
      osc_settings_t s;
      s = '0;
      s.osc_off = w[1:0] == MODE_OFF;
      s.high_speed_crystal_mode = w[1:0] == MODE_HS;
      s.standard_crystal_mode = w[1:0] == MODE_XT;
      s.external_clock_input_mode = w[1:0] == MODE_EC;
      s.crystal_drive_gain = w[11:10];
      s.kick_start_boost = w[12];
      s.pll_lock_gate_enable = w[8];
      s.switch_enable = !w[7];
      s.monitor_enable = w[7:6] == SWMODE_BOTH;
      // crystal modes own the pin, so neither function is offered
      s.pin_clock_out = !s.high_speed_crystal_mode && !s.standard_crystal_mode && w[2];
      s.pin_gpio = !s.high_speed_crystal_mode && !s.standard_crystal_mode && !w[2];
      return s;
   endfunction

   task run_word(input logic [CFG_W-1:0] w);
      osc_settings_t e;
      logic [31:0] stored;
      e = exp_set(w);
      stored = {8'h00, w | CFG_UNIMPL};
      @(posedge pclk);
      presetn <= 1'b0;
      nvm_word <= w;
      pll_request <= 1'b0;
      power_on <= 1'b0;
      drop_lock <= 1'b0;
      repeat (5) @(posedge pclk);
      check(settings === SETTINGS_RESET && cfg_valid === 1'b0, "outputs in reset");
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      check(cfg_valid === 1'b0, "word valid too early");
      @(negedge pclk);
      check(cfg_valid === 1'b1, "word not loaded");
      @(negedge pclk);
      check(settings[11:2] === e[11:2], "decode mismatch");
      check(settings[1:0] === e[1:0], "pin function");
      apb(1'b0, OFF_CFG, 32'h0);
      check(rd === stored && err === 1'b0, "cfg read");
      apb(1'b1, OFF_CFG, ~stored);
      apb(1'b0, OFF_CFG, 32'h0);
      check(rd === stored && settings === e, "cfg altered by write");
      // running pll answers promptly, stopped pll slowly
      @(posedge pclk);
      power_on <= w[16];
      pll_request <= 1'b1;
      n = 0;
      while (switch_busy !== 1'b1 && pll_selected !== 1'b1 && n < 20) begin
         @(negedge pclk);
         n++;
      end
      if (!e.switch_enable) begin
         check(n == 20 && pll_selected === 1'b0, "switch while disabled");
         apb(1'b0, OFF_STATUS, 32'h0);
         check(rd[EVT_REFUSED] === 1'b1 && rd[EVT_DONE] === 1'b0, "refusal not flagged");
      end else if (w[16]) begin
         check(pll_selected === 1'b1 && switch_busy === 1'b0, "running pll switch");
      end else begin
         n = 0;
         while (pll_selected !== 1'b1 && n < 20) begin
            @(negedge pclk);
            n++;
         end
         check(n == WAIT && switch_busy === 1'b0, "pll wait length");
      end
      if (e.switch_enable) begin
         apb(1'b0, OFF_STATUS, 32'h0);
         check(rd[EVT_DONE] === 1'b1 && rd[EVT_REFUSED] === 1'b0, "done flag");
      end
      @(posedge pclk);
      power_on <= 1'b1;
      pll_request <= 1'b0;
      repeat (12) @(posedge pclk);
      check(pll_clock_enable === 1'b1, "pll output with lock");
      drop_lock <= 1'b1;
      repeat (6) @(negedge pclk);
      check(pll_clock_enable === !e.pll_lock_gate_enable, "lock gating");
      apb(1'b0, OFF_STATUS, 32'h0);
      check(rd[EVT_LOCKLOST] === e.pll_lock_gate_enable, "lock lost flag");
   endtask

   initial begin
      void'($urandom(32'hbe0e947c));
      run_word(24'h000000);
      apb(1'b0, OFF_ENABLE, 32'h0);
      check(rd === 32'h0, "enable reset value");
      apb(1'b1, OFF_CLEAR, 32'hf);
      apb(1'b1, OFF_ENABLE, 32'h8);
      apb(1'b1, OFF_CFG, 32'h0);
      repeat (2) @(negedge pclk);
      check(irq === 1'b1, "irq on cfg write");
      apb(1'b1, OFF_CLEAR, 32'h8);
      repeat (2) @(negedge pclk);
      check(irq === 1'b0, "irq after clear");
      apb(1'b1, OFF_ENABLE, 32'h0);
      apb(1'b1, OFF_CFG, 32'h0);
      apb(1'b0, OFF_STATUS, 32'h0);
      check(irq === 1'b0 && rd[EVT_WRITE] === 1'b1, "masked event");
      apb(1'b0, 12'h020, 32'h0);
      check(err === 1'b1 && rd === 32'h0, "unmapped access");
      apb(1'b0, OFF_SWSTATE, 32'h0);
      check(rd[0] === 1'b1, "loaded state");
      // corner words: every mode and every switch code
      for (int i = 0; i < 4; i++) begin
         r = $urandom;
         r[1:0] = 2'(i);
         r[7:6] = 2'(i);
         r[16] = r[2];
         run_word(r[CFG_W-1:0]);
      end
      repeat (6) begin
         r = $urandom;
         run_word(r[CFG_W-1:0]);
      end
      complete_run;
   end

   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      $display("CHECK FAILED at %0t: run hung", $time);
      complete_run;
   end
endmodule
